// ==== cond_branch_cfg.svh ====
// constants for the conditional branch decoder
`ifndef COND_BRANCH_CFG_SVH
`define COND_BRANCH_CFG_SVH

`define CB_OPC_NONNEG    8'he7
`define CB_OPC_NOOVF     8'he5
`define CB_PC_WIDTH      21
`define CB_PC_STEP       21'h000002
`define CB_PC_RESET      21'h000000
`define CB_PHASES        4

`endif

// ==== cond_branch_flag_clear.sv ====
// decode and execute of branch-if-nonnegative and branch-if-no-overflow
`timescale 1ns/100ps
`include "cond_branch_cfg.svh"

module cond_branch_flag_clear
    import cond_branch_pkg::*;
(
    input  wire logic                    i_clk,
    input  wire logic                    i_reset,
    input  wire logic                    i_instr_valid,
    input  wire logic [15:0]             i_instr,
    input  wire logic [`CB_PC_WIDTH-1:0] i_pc,
    input  wire flags_t                  i_flags,
    output logic                         o_busy,
    output logic                         o_pc_write,
    output logic [`CB_PC_WIDTH-1:0]      o_pc_target,
    output logic                         o_flush,
    output logic                         o_done,
    output logic [1:0]                   o_phase
);

    // ------------------------------------------------------------
    // timing overview
    // ------------------------------------------------------------
    // one instruction cycle is four clocks, q1..q4, counted by phase_q.
    // q1 edge: the fetched word is classified and its address + 2 kept.
    // q2 edge: the offset literal is latched; fetch must hold the word.
    // q3 edge: the flags are sampled and the decision is registered;
    //          the target is registered at the same edge.
    // q4     : o_pc_write pulses for a taken branch, else o_done pulses.
    // a taken branch then spends one whole cycle as a flush, in which
    // the word on the fetch port is dropped and o_done pulses at its q4.
    // flags are only read; nothing here ever writes them back.
    // limitation: the decision uses the flags as seen in q3, so an
    // instruction that updates them must have done so by then.

    // ------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------

    // classify an instruction word; only the two flag-clear branches
    function automatic decode_t decode_word(input logic [15:0] w);
        decode_t d;
        d.is_nonneg = (w[15:8] == `CB_OPC_NONNEG);
        d.is_branch = d.is_nonneg || (w[15:8] == `CB_OPC_NOOVF);
        d.offset    = w[7:0];
        return d;
    endfunction : decode_word

    // branch condition: each instruction tests its own flag for zero;
    // shared by the q3 decision, the q4 write strobe and the done strobe
    function automatic logic branch_taken(input logic   nonneg,
                                          input flags_t flags);
        logic t;
        if (nonneg) begin
            t = !flags.negative;
        end else begin
            t = !flags.overflow;
        end
        return t;
    endfunction : branch_taken

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    phase_t                  phase_q;
    logic                    active_q;     // branch instruction in its first cycle
    logic                    flush_q;      // second, no-operation cycle
    logic                    nonneg_q;
    logic [7:0]              offset_q;     // literal latched in q2
    logic                    take_q;       // decision made in q3
    logic [`CB_PC_WIDTH-1:0] pc_next_q;
    logic [`CB_PC_WIDTH-1:0] target_w;
    decode_t                 dec_w;

    assign dec_w = decode_word(i_instr);

    cond_branch_target u_target (
        .i_pc_next (pc_next_q),
        .i_offset  (offset_q),
        .o_target  (target_w)
    );

    // ------------------------------------------------------------
    // four-phase instruction cycle
    // ------------------------------------------------------------

    // phase counter free-runs; each instruction cycle is q1..q4
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            phase_q <= PH_Q1;
        end else begin
            case (phase_q)
                PH_Q1:   phase_q <= PH_Q2;
                PH_Q2:   phase_q <= PH_Q3;
                PH_Q3:   phase_q <= PH_Q4;
                default: phase_q <= PH_Q1;
            endcase
        end
    end

    // q1 decode: accept a word only at cycle start and not during flush
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            active_q  <= 1'b0;
            nonneg_q  <= 1'b0;
            pc_next_q <= `CB_PC_RESET;
        end else if (phase_q == PH_Q1) begin
            active_q  <= i_instr_valid && dec_w.is_branch && !flush_q;
            nonneg_q  <= dec_w.is_nonneg;
            pc_next_q <= i_pc + `CB_PC_STEP;
        end else if (phase_q == PH_Q4) begin
            active_q  <= 1'b0;
        end
    end

    // q2 read literal; word held stable by fetch across the cycle
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            offset_q <= 8'h00;
        end else if (phase_q == PH_Q2 && active_q) begin
            // the literal comes from the word as it stands in q2
            offset_q <= dec_w.offset;
        end
    end

    // ------------------------------------------------------------
    // decision and program counter write
    // ------------------------------------------------------------

    // q3 process: flags sampled here, never written back
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            take_q <= 1'b0;
        end else if (phase_q == PH_Q3) begin
            take_q <= active_q && branch_taken(nonneg_q, i_flags);
        end
    end

    // q4 write pc when taken; not-taken makes no write
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_pc_write  <= 1'b0;
            o_pc_target <= `CB_PC_RESET;
        end else begin
            // strobe only in q4 and only for a taken branch
            o_pc_write  <= (phase_q == PH_Q3) && active_q
                           && branch_taken(nonneg_q, i_flags);
            if (phase_q == PH_Q3) begin
                o_pc_target <= target_w;
            end
        end
    end

    // taken branch costs a second cycle spent as a no-operation flush
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            flush_q <= 1'b0;
        end else if (phase_q == PH_Q4) begin
            flush_q <= take_q;
        end
    end

    // ------------------------------------------------------------
    // status outputs
    // ------------------------------------------------------------

    // busy trails the decode by one phase: the branch is only known
    // once q1 has been sampled, so neither q1 nor q2 of the first cycle shows busy
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_busy <= 1'b0;
        end else if (phase_q == PH_Q4) begin
            o_busy <= take_q;
        end else begin
            o_busy <= active_q || flush_q;
        end
    end

    // flush level covers the four phases of the no-operation cycle
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_flush <= 1'b0;
        end else if (phase_q == PH_Q4) begin
            o_flush <= take_q;
        end else begin
            o_flush <= flush_q;
        end
    end

    // done pulses in the last q4: first cycle if not taken, else flush
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_done <= 1'b0;
        end else begin
            o_done <= (phase_q == PH_Q3)
                      && ((active_q && !branch_taken(nonneg_q, i_flags))
                          || flush_q);
        end
    end

    // phase copy for the core, registered so the port comes from a flop
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_phase <= 2'h0;
        end else begin
            case (phase_q)
                PH_Q1:   o_phase <= 2'h1;
                PH_Q2:   o_phase <= 2'h2;
                PH_Q3:   o_phase <= 2'h3;
                default: o_phase <= 2'h0;
            endcase
        end
    end

endmodule : cond_branch_flag_clear

// ==== cond_branch_flag_clear_properties.sv ====
// concurrent checks on the branch decoder ports
`timescale 1ns/100ps
`include "cond_branch_cfg.svh"
module cond_branch_checker
    import cond_branch_pkg::*;
(
    input wire logic                    i_clk,
    input wire logic                    i_reset,
    input wire logic                    i_instr_valid,
    input wire logic [15:0]             i_instr,
    input wire logic [`CB_PC_WIDTH-1:0] i_pc,
    input wire flags_t                  i_flags,
    input wire logic                    o_pc_write,
    input wire logic [`CB_PC_WIDTH-1:0] o_pc_target,
    input wire logic                    o_flush,
    input wire logic                    o_done,
    input wire logic [1:0]              o_phase
);
    logic [`CB_PC_WIDTH-1:0] tgt_q;
    wire logic q1 = o_phase == 2'h0 && !o_flush;
    wire logic nn = q1 && i_instr_valid && i_instr[15:8] == `CB_OPC_NONNEG;
    wire logic nv = q1 && i_instr_valid && i_instr[15:8] == `CB_OPC_NOOVF;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);
    // --------------------------------
    // target model, taken with the word in q1
    // --------------------------------
    always_ff @(posedge i_clk) begin
        if (o_phase == 2'h0)
            tgt_q <= i_pc + `CB_PC_STEP + {{12{i_instr[7]}}, i_instr[7:0], 1'b0};
    end
    property p_pw; o_pc_write |-> o_phase == 2'h3; endproperty
    a_pw: assert property (p_pw) else $error("pc write outside q4");
    property p_tgt; o_pc_write |-> o_pc_target == tgt_q; endproperty
    a_tgt: assert property (p_tgt) else $error("wrong target");
    property p_nn; nn ##2 !i_flags.negative |-> ##1 o_pc_write; endproperty
    a_nn: assert property (p_nn) else $error("nonneg not taken");
    property p_nv; nv ##2 !i_flags.overflow |-> ##1 o_pc_write; endproperty
    a_nv: assert property (p_nv) else $error("no overflow not taken");
    property p_miss; (nn ##2 i_flags.negative) or (nv ##2 i_flags.overflow)
        |-> ##1 o_done && !o_pc_write; endproperty
    a_miss: assert property (p_miss) else $error("bad not taken end");
    property p_fl; o_pc_write |=> o_flush [*4] ##1 !o_flush; endproperty
    a_fl: assert property (p_fl) else $error("flush length");
    property p_dn; o_pc_write |-> ##4 o_done; endproperty
    a_dn: assert property (p_dn) else $error("taken done late");
    property p_ign; q1 && !nn && !nv |-> ##3 !o_pc_write && !o_done; endproperty
    a_ign: assert property (p_ign) else $error("other word acted on");
endmodule : cond_branch_checker
bind cond_branch_flag_clear cond_branch_checker u_chk (.*);

// ==== cond_branch_pkg.sv ====
// types shared by the conditional branch decoder files
package cond_branch_pkg;

    typedef enum logic [1:0] {
        PH_Q1,
        PH_Q2,
        PH_Q3,
        PH_Q4
    } phase_t;

    typedef struct packed {
        logic        is_branch;
        logic        is_nonneg;
        logic [7:0]  offset;
    } decode_t;

    typedef struct packed {
        logic        negative;
        logic        overflow;
    } flags_t;

endpackage : cond_branch_pkg

// ==== cond_branch_target.sv ====
// branch target adder: pc plus twice the signed offset
`timescale 1ns/100ps
`include "cond_branch_cfg.svh"

module cond_branch_target
    import cond_branch_pkg::*;
(
    input  wire logic [`CB_PC_WIDTH-1:0] i_pc_next,
    input  wire logic [7:0]              i_offset,
    output logic      [`CB_PC_WIDTH-1:0] o_target
);

    // sign extend then double; pc already holds own address plus two
    always_comb begin
        o_target = i_pc_next
                 + {{(`CB_PC_WIDTH-9){i_offset[7]}}, i_offset, 1'b0};
    end

endmodule : cond_branch_target

// ==== tb.sv ====
// self-checking bench for the conditional branch decoder
`timescale 1ns/100ps
`include "cond_branch_cfg.svh"
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin n_errors++; \
    $display("BAD %s exp %h got %h", n, e, s); end end
module tb import cond_branch_pkg::*; ;
    logic                    i_clk = 1'b0, i_reset = 1'b1, i_instr_valid = 1'b0;
    logic [15:0]             i_instr = 16'h0000;
    logic [`CB_PC_WIDTH-1:0] i_pc = '0, o_pc_target;
    flags_t                  i_flags = 2'h0;
    logic                    o_busy, o_pc_write, o_flush, o_done;
    logic [1:0]              o_phase;
    int                      n_errors = 0, checks = 0;
    cond_branch_flag_clear dut (.*);
    // ---------------
    // clock, watchdog
    // ---------------
    initial forever #2.5 i_clk = ~i_clk;
    initial begin
        repeat (1000) @(posedge i_clk);
        n_errors++;
        report_and_stop();
    end
    task automatic report_and_stop;
        if (n_errors == 0 && checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : report_and_stop
    // one branch in q1, judged at q4 and through the flush cycle
    task automatic br(input logic [15:0] w, input logic [20:0] pc, input flags_t f,
                      input logic wr, input logic dn);
        logic [20:0] t;
        t = pc + `CB_PC_STEP + {{12{w[7]}}, w[7:0], 1'b0};
        while (o_phase !== 2'h0) @(negedge i_clk);
        i_instr_valid = 1'b1;
        i_instr = w;
        i_pc = pc;
        i_flags = f;
        repeat (3) @(negedge i_clk);
        `CHK("pc_write", wr, o_pc_write)
        `CHK("done", dn, o_done)
        `CHK("busy", wr | dn, o_busy)
        `CHK("q4_flush", 1'b0, o_flush)
        `CHK("phase", 2'h3, o_phase)
        if (wr) begin
            `CHK("target", t, o_pc_target)
            i_instr = 16'he700; // a branch fetched into the flush must die
            repeat (4) begin
                @(negedge i_clk);
                `CHK("flush", 1'b1, o_flush)
                `CHK("flush_busy", 1'b1, o_busy)
            end
            `CHK("flush_write", 1'b0, o_pc_write)
            `CHK("flush_done", 1'b1, o_done)
        end
    endtask : br
    task automatic t_nonneg;
        br(16'he77f, 21'h000100, 2'h1, 1'b1, 1'b0);
        br(16'he701, 21'h1ffffe, 2'h0, 1'b1, 1'b0);
        br(16'he700, 21'h000040, 2'h2, 1'b0, 1'b1);
    endtask : t_nonneg
    task automatic t_noovf;
        br(16'he580, 21'h000100, 2'h2, 1'b1, 1'b0);
        br(16'he5ff, 21'h000200, 2'h1, 1'b0, 1'b1);
    endtask : t_noovf
    task automatic t_other;
        br(16'he6ff, 21'h000300, 2'h0, 1'b0, 1'b0);
    endtask : t_other
    // reset in q2 of a taken branch must cancel it and restart at q1
    task automatic t_reset;
        while (o_phase !== 2'h0) @(negedge i_clk);
        i_instr_valid = 1'b1;
        i_instr = 16'he77f;
        i_flags = 2'h0;
        @(negedge i_clk);
        i_reset = 1'b1;
        @(negedge i_clk);
        `CHK("mid_phase", 2'h0, o_phase)
        `CHK("mid_busy", 1'b0, o_busy)
        i_reset = 1'b0;
        i_instr_valid = 1'b0;
        repeat (3) @(negedge i_clk);
        `CHK("mid_write", 1'b0, o_pc_write)
        `CHK("mid_phase_q4", 2'h3, o_phase)
    endtask : t_reset
    // a branch word without its valid flag must be left alone
    task automatic t_idle;
        while (o_phase !== 2'h0) @(negedge i_clk);
        i_instr_valid = 1'b0;
        i_instr = 16'he700;
        i_flags = 2'h0;
        repeat (3) @(negedge i_clk);
        `CHK("idle_write", 1'b0, o_pc_write)
        `CHK("idle_done", 1'b0, o_done)
        `CHK("idle_busy", 1'b0, o_busy)
    endtask : t_idle
    initial begin
        repeat (2) @(negedge i_clk);
        `CHK("rst_phase", 2'h0, o_phase)
        `CHK("rst_write", 1'b0, o_pc_write)
        `CHK("rst_target", 21'h0, o_pc_target)
        `CHK("rst_status", 3'h0, {o_busy, o_flush, o_done})
        i_reset = 1'b0;
        @(negedge i_clk);
        t_nonneg();
        t_noovf();
        t_reset();
        t_other();
        t_idle();
        report_and_stop();
    end
endmodule : tb
